/* File: rtl/sub_bridge.sv */
`timescale 1ns/1ps
module sub_bridge
   import sub_pkg::*;
(
   input  wire logic       CLK_SYS,
   input  wire logic       SYS_RST,
   input  wire logic       SPI_SCLK,
   input  wire logic       SPI_CS_N,
   input  wire logic       SPI_MOSI,
   output logic            SPI_MISO,
   output logic            SPI_MISO_OE,
   output logic [7:0]      UART_TX_DATA,
   output logic            UART_TX_VALID,
   input  wire logic       UART_TX_READY,
   input  wire logic [7:0] UART_RX_DATA,
   input  wire logic       UART_RX_VALID,
   input  wire logic       UART_RX_STOP,
   input  wire logic       UART_RX_ERR,
   input  wire logic [7:0] LOCKSTEP_STATUS
);
   import sub_pkg::*;

   logic [2:0]    sclk_s, cs_s, mosi_s;
   logic [2:0]    bit_cnt;
   logic [7:0]    shift_in, shift_out, byte_in, next_resp, status;
   logic [7:0]    cmd, byte_idx, ld_len, ld_cnt, rd_ptr;
   logic          rise, fall, cs_rise, cs_fall, byte_done, tq_we, adv_req;
   logic          msg_release, stat_clear;
   logic [7:0]    tx_mem [0:(1<<TXQ_AW)-1];
   logic [7:0]    tx_rptr, tx_len;
   logic          tx_run, push, pop, in_ready;
   logic [7:0]    b0, b1;
   logic [1:0]    b_cnt;
   logic [7:0]    rx_mem [0:(1<<RXB_AW)-1];
   logic [7:0]    rx_wptr, rx_len, crc, rx_wd;
   logic          rx_we, rx_stop, rx_err, rx_ovf;
   logic [RXB_AW-1:0] rd_idx, rx_widx;
   sub_rx_state_t rx_state;

   // One CRC-8 step over a byte, MSB first
   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] r;
      r = c ^ d;
      for (int i = 0; i < 8; i++) begin
         r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
      end
      return r;
   endfunction

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (SYS_RST);

   ////////////////////////////////////////////////////////////////////////////////
   // SPI pin synchronisers; stage 0 feeds only stage 1
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         sclk_s <= 3'h0;
         cs_s   <= 3'h7;
         mosi_s <= 3'h0;
      end else begin
         sclk_s <= {sclk_s[1:0], SPI_SCLK};
         cs_s   <= {cs_s[1:0], SPI_CS_N};
         mosi_s <= {mosi_s[1:0], SPI_MOSI};
      end
   end

   // Edge detection on synchronised levels
   assign rise      = sclk_s[1] & ~sclk_s[2] & ~cs_s[1];
   assign fall      = ~sclk_s[1] & sclk_s[2] & ~cs_s[1];
   assign cs_rise   = cs_s[1] & ~cs_s[2];
   assign cs_fall   = ~cs_s[1] & cs_s[2];
   assign byte_in   = {shift_in[6:0], mosi_s[1]};
   assign byte_done = rise & (bit_cnt == BIT_LAST);
   assign tq_we     = byte_done & (cmd == CMD_LOAD_QUEUE) & (byte_idx >= IDX_DATA)
                      & (ld_cnt < ld_len) & (ld_cnt < TXQ_DEPTH);
   assign msg_release = cs_rise & (cmd == CMD_READ_NEXT);
   assign stat_clear  = cs_rise & (cmd == CMD_READ_STATUS);
   assign SPI_MISO    = shift_out[7];
   assign SPI_MISO_OE = ~cs_s[1];
   assign rd_idx      = rd_ptr[RXB_AW-1:0];   // Buffer read slot
   assign rx_widx     = rx_wptr[RXB_AW-1:0];  // Buffer write slot

   // Receive status byte
   always_comb begin
      status = 8'h00;
      status[ST_ERR_BIT]  = rx_err;
      status[ST_STOP_BIT] = rx_stop;
      status[ST_OVF_BIT]  = rx_ovf;
   end

   // Next byte to present on the data out pin
   always_comb begin
      next_resp = 8'h00;
      if (byte_idx == IDX_CMD) begin
         if (byte_in == CMD_READ_STATUS) begin
            next_resp = status;
         end else if (byte_in == CMD_READ_NEXT && rx_stop) begin
            next_resp = rx_mem[0];
         end
      end else if (cmd == CMD_READ_NEXT && rx_stop && rd_ptr < rx_len) begin
         next_resp = rx_mem[rd_idx];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Bit shifting, mode 0: capture on rising, shift on falling, next byte loaded on the eighth rising
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         bit_cnt   <= 3'h0;
         shift_in  <= 8'h00;
         shift_out <= 8'h00;
      end else if (cs_fall) begin
         bit_cnt   <= 3'h0;
         shift_out <= 8'h00;
      end else if (byte_done) begin
         bit_cnt   <= 3'h0;
         shift_in  <= byte_in;
         shift_out <= next_resp;
      end else if (rise) begin
         bit_cnt  <= bit_cnt + 3'h1;
         shift_in <= byte_in;
      end else if (fall && bit_cnt != 3'h0) begin
         shift_out <= {shift_out[6:0], 1'b0};
      end
   end

   // Command decode and byte position tracking
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         cmd      <= 8'h00;
         byte_idx <= IDX_CMD;
         ld_len   <= 8'h00;
         ld_cnt   <= 8'h00;
         rd_ptr   <= 8'h00;
         adv_req  <= 1'b0;
      end else begin
         adv_req <= 1'b0;
         if (cs_fall) begin
            byte_idx <= IDX_CMD;
         end else if (cs_rise) begin
            cmd <= 8'h00;
         end else if (byte_done) begin
            if (byte_idx != IDX_MAX) begin
               byte_idx <= byte_idx + 8'h01;
            end
            if (byte_idx == IDX_CMD) begin
               cmd     <= byte_in;
               rd_ptr  <= 8'h01;
               adv_req <= (byte_in == CMD_ADVANCE_QUEUE);
            end else if (cmd == CMD_LOAD_QUEUE && byte_idx == IDX_LEN) begin
               ld_len <= byte_in;
               ld_cnt <= 8'h00;
            end else if (tq_we) begin
               ld_cnt <= ld_cnt + 8'h01;
            end else if (cmd == CMD_READ_NEXT) begin
               rd_ptr <= rd_ptr + 8'h01;
            end
         end
      end
   end

   // Transmit queue storage
   always_ff @(posedge CLK_SYS) begin
      if (tq_we) begin
         tx_mem[ld_cnt[TXQ_AW-1:0]] <= byte_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Queue drain: bytes leave unmodified, check and alive bytes included
   assign in_ready = (b_cnt != 2'h2);
   assign push     = tx_run & in_ready;
   assign pop      = UART_TX_VALID & UART_TX_READY;
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         tx_run  <= 1'b0;
         tx_rptr <= 8'h00;
         tx_len  <= 8'h00;
      end else if (adv_req && !tx_run && ld_cnt != 8'h00) begin
         tx_run  <= 1'b1;
         tx_rptr <= 8'h00;
         tx_len  <= ld_cnt;
      end else if (push) begin
         tx_rptr <= tx_rptr + 8'h01;
         tx_run  <= (tx_rptr + 8'h01 != tx_len);
      end
   end

   // Two-entry buffer toward the UART so a stall loses no byte
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         b0    <= 8'h00;
         b1    <= 8'h00;
         b_cnt <= 2'h0;
      end else begin
         case ({push, pop})
            2'b10: begin
               if (b_cnt == 2'h0) b0 <= tx_mem[tx_rptr[TXQ_AW-1:0]];
               else b1 <= tx_mem[tx_rptr[TXQ_AW-1:0]];
               b_cnt <= b_cnt + 2'h1;
            end
            2'b01: begin
               b0    <= b1;
               b_cnt <= b_cnt - 2'h1;
            end
            2'b11: begin
               if (b_cnt == 2'h1) b0 <= tx_mem[tx_rptr[TXQ_AW-1:0]];
               else begin
                  b0 <= b1;
                  b1 <= tx_mem[tx_rptr[TXQ_AW-1:0]];
               end
            end
            default: b_cnt <= b_cnt;
         endcase
      end
   end
   assign UART_TX_VALID = (b_cnt != 2'h0);
   assign UART_TX_DATA  = b0;

   ////////////////////////////////////////////////////////////////////////////////
   // Receive buffer write selection
   always_comb begin
      rx_we = 1'b0;
      rx_wd = 8'h00;
      case (rx_state)
         RX_DATA: begin
            rx_we = UART_RX_VALID & ~rx_stop & (rx_wptr < RXB_DATA_MAX);
            rx_wd = UART_RX_DATA;
         end
         RX_LS: begin
            rx_we = 1'b1;
            rx_wd = LOCKSTEP_STATUS;
         end
         RX_PEC: begin
            rx_we = 1'b1;
            rx_wd = crc;
         end
         default: rx_we = 1'b0;
      endcase
   end

   always_ff @(posedge CLK_SYS) begin
      if (rx_we) begin
         rx_mem[rx_widx] <= rx_wd;
      end
   end

   // Receive framing, check byte and error flags
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         rx_state <= RX_DATA;
         rx_wptr  <= 8'h00;
         rx_len   <= 8'h00;
         crc      <= CRC_INIT;
         rx_stop  <= 1'b0;
         rx_err   <= 1'b0;
         rx_ovf   <= 1'b0;
      end else begin
         // Only a held message is freed; a partial one keeps its bytes
         if (msg_release && rx_stop) begin
            rx_stop <= 1'b0;
            rx_wptr <= 8'h00;
            crc     <= CRC_INIT;
         end
         if (stat_clear) begin
            rx_err <= 1'b0;
            rx_ovf <= 1'b0;
         end
         if (UART_RX_ERR) rx_err <= 1'b1;  // Set wins over clear
         // Bytes during the append cycles are dropped and flagged too
         if (UART_RX_VALID && (rx_state != RX_DATA || !rx_we)) rx_ovf <= 1'b1;
         if (rx_we) begin
            rx_wptr <= rx_wptr + 8'h01;
            if (rx_state != RX_PEC) crc <= crc8(crc, rx_wd);
         end
         case (rx_state)
            RX_DATA: if (UART_RX_STOP && !rx_stop) rx_state <= RX_LS;
            RX_LS:   rx_state <= RX_PEC;
            RX_PEC: begin
               rx_state <= RX_DATA;
               rx_len   <= rx_wptr + 8'h01;
               rx_stop  <= 1'b1;
            end
            default: rx_state <= RX_DATA;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   chk_stop_status: assert property (rx_state == RX_PEC |=> status[ST_STOP_BIT])
      else $error("stop bit");
   chk_append_order: assert property (UART_RX_STOP && !rx_stop && rx_state == RX_DATA |=>
      rx_state == RX_LS ##1 rx_state == RX_PEC ##1 rx_stop) else $error("append order");
   chk_ls_stored: assert property (rx_state == RX_LS |=>
      rx_mem[$past(rx_widx)] == $past(LOCKSTEP_STATUS)) else $error("ls byte");
   chk_pec_stored: assert property (rx_state == RX_PEC |=>
      rx_mem[$past(rx_widx)] == $past(crc)) else $error("pec byte");
   chk_advance_start: assert property (adv_req && !tx_run && ld_cnt != 8'h00 |=>
      tx_run && tx_rptr == 8'h00) else $error("advance");
   chk_read_next: assert property (byte_done && byte_idx != IDX_CMD
      && cmd == CMD_READ_NEXT && rx_stop && rd_ptr < rx_len |=>
      shift_out == rx_mem[$past(rd_idx)]) else $error("read");
   chk_cmd_first: assert property (cs_fall |=> byte_idx == IDX_CMD) else $error("cmd pos");
   chk_tx_hold: assert property (UART_TX_VALID && !UART_TX_READY |=>
      UART_TX_VALID && $stable(UART_TX_DATA)) else $error("tx stall");
   chk_err_sticky: assert property (UART_RX_ERR |=> rx_err) else $error("err flag");
endmodule

/* File: inc/sub_pkg.sv */
package sub_pkg;
   // SPI command bytes
   localparam logic [7:0] CMD_LOAD_QUEUE    = 8'hC0;
   localparam logic [7:0] CMD_ADVANCE_QUEUE = 8'hB0;
   localparam logic [7:0] CMD_READ_STATUS   = 8'h01;
   localparam logic [7:0] CMD_READ_NEXT     = 8'h93;
   // Byte positions inside one SPI transaction
   localparam logic [7:0] IDX_CMD  = 8'h00;
   localparam logic [7:0] IDX_LEN  = 8'h01;
   localparam logic [7:0] IDX_DATA = 8'h02;
   localparam logic [7:0] IDX_MAX  = 8'hFF;
   localparam logic [2:0] BIT_LAST = 3'h7;
   // Transmit queue and receive buffer sizes
   localparam int         TXQ_AW      = 4;
   localparam logic [7:0] TXQ_DEPTH   = 8'h10;
   localparam int         RXB_AW      = 5;
   localparam logic [7:0] RXB_DATA_MAX = 8'h1E;  // Leaves room for status and check bytes
   // Receive status bit positions
   localparam int ST_ERR_BIT  = 0;
   localparam int ST_STOP_BIT = 1;
   localparam int ST_OVF_BIT  = 2;
   // Packet check code
   localparam logic [7:0] CRC_POLY = 8'h07;
   localparam logic [7:0] CRC_INIT = 8'h00;
   // Receive framing states
   typedef enum logic [1:0] {RX_DATA, RX_LS, RX_PEC} sub_rx_state_t;
endpackage

/* File: verif/sub_host.sv */
`timescale 1ns/1ps
// Host side SPI master, mode 0, MSB first
module sub_host (
   input  wire logic CLK_SYS,
   output logic      SPI_SCLK,
   output logic      SPI_CS_N,
   output logic      SPI_MOSI,
   input  wire logic SPI_MISO
);
   localparam int HALF = 6;  // System cycles per SCLK phase, above the minimum of 3
   logic [7:0] got [$];

   // Idle levels at time zero
   initial begin
      SPI_SCLK = 1'b0;
      SPI_CS_N = 1'b1;
      SPI_MOSI = 1'b0;
   end

   ////////////////////////////////////////
   // Wait a number of falling system edges
   task automatic fall(input int n);
      repeat (n) @(negedge CLK_SYS);
   endtask

   // One transaction; reply bytes land in got, first entry pairs with the command
   task automatic xfer(input logic [7:0] tx [$]);
      logic [7:0] b;
      got.delete();
      fall(1);
      SPI_CS_N = 1'b0;
      fall(HALF);
      foreach (tx[i]) begin
         for (int k = 7; k >= 0; k--) begin
            SPI_MOSI = tx[i][k];
            fall(HALF);
            b[k] = SPI_MISO;  // Sampled as the clock rises, before the next byte loads
            SPI_SCLK = 1'b1;
            fall(HALF);
            SPI_SCLK = 1'b0;
         end
         got.push_back(b);
      end
      fall(HALF);
      SPI_CS_N = 1'b1;
      SPI_MOSI = ~SPI_MOSI;  // Released line shows no stale bit
      fall(HALF);
   endtask
endmodule

/* File: verif/sub_bridge_tb_top.sv */
`timescale 1ns/1ps
module sub_bridge_tb_top;
   import sub_pkg::*;
   logic       clk_sys = 1'b0;
   logic       sys_rst = 1'b1;
   logic       sclk, cs_n, mosi, miso, miso_oe, tx_v;
   logic       rdy     = 1'b0;
   logic       rx_v    = 1'b0;
   logic       rx_stop = 1'b0;
   logic       rx_err  = 1'b0;
   logic [7:0] tx_d;
   logic [7:0] rx_d    = 8'h00;
   logic [7:0] ls      = 8'h84;
   logic [7:0] sent [$];
   int         mismatches  = 0;
   int         checks_done = 0;

   sub_host host (.CLK_SYS(clk_sys), .SPI_SCLK(sclk), .SPI_CS_N(cs_n), .SPI_MOSI(mosi),
                  .SPI_MISO(miso));
   sub_bridge dut (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .SPI_SCLK(sclk), .SPI_CS_N(cs_n),
      .SPI_MOSI(mosi), .SPI_MISO(miso), .SPI_MISO_OE(miso_oe), .UART_TX_DATA(tx_d),
      .UART_TX_VALID(tx_v), .UART_TX_READY(rdy), .UART_RX_DATA(rx_d),
      .UART_RX_VALID(rx_v), .UART_RX_STOP(rx_stop), .UART_RX_ERR(rx_err),
      .LOCKSTEP_STATUS(ls));

   ////////////////////////////////////////
   // Clock, and a chain end that stalls every other cycle
   always #50 clk_sys = ~clk_sys;
   always @(negedge clk_sys)
      rdy = ~rdy;
   always @(posedge clk_sys)
      if (tx_v === 1'b1 && rdy)
         sent.push_back(tx_d);

   // Reference check code over a byte list
   function automatic logic [7:0] crc8(input logic [7:0] q [$]);
      logic [7:0] c;
      c = CRC_INIT;
      foreach (q[i]) begin
         c ^= q[i];
         repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ CRC_POLY : {c[6:0], 1'b0};
      end
      return c;
   endfunction

   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic close_out();
      $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // One-cycle strobe toward the bridge
   task automatic pulse(ref logic s);
      @(negedge clk_sys);
      s = 1'b1;
      @(negedge clk_sys);
      s = 1'b0;
   endtask

   // Chain returns a message, then its stop character
   task automatic back(input logic [7:0] m [$]);
      foreach (m[i]) begin
         rx_d = m[i];
         pulse(rx_v);
      end
      pulse(rx_stop);
      repeat (4) @(negedge clk_sys);
   endtask

   task automatic stat(input logic [7:0] e);
      host.xfer('{CMD_READ_STATUS, 8'h00});
      cmp(host.got[1], e);
   endtask

   // Load, send, wait for the loop-back, read it and check status
   task automatic round(input logic [7:0] q [$], input logic [7:0] r [$]);
      logic [7:0] e [$];
      int n;
      sent.delete();
      e = '{CMD_LOAD_QUEUE, 8'(q.size())};
      foreach (q[i]) e.push_back(q[i]);
      host.xfer(e);
      host.xfer('{CMD_ADVANCE_QUEUE});
      for (n = 0; n < 500 && sent.size() < q.size(); n++)
         @(negedge clk_sys);
      if (sent.size() < q.size()) begin
         mismatches++;
         close_out();
      end
      foreach (q[i]) cmp(sent[i], q[i]);
      back(r);
      for (n = 0; n < 20; n++) begin
         host.xfer('{CMD_READ_STATUS, 8'h00});
         if (host.got[1][ST_STOP_BIT] === 1'b1)
            break;
      end
      if (n == 20) begin
         mismatches++;
         close_out();
      end
      cmp(host.got[1], 8'h02);
      e = '{CMD_READ_NEXT};
      repeat (r.size() + 3) e.push_back(8'h00);
      host.xfer(e);
      foreach (r[i]) cmp(host.got[i + 1], r[i]);
      r.push_back(ls);
      cmp(host.got[r.size()], ls);
      cmp(host.got[r.size() + 1], crc8(r));
      cmp(host.got[r.size() + 2], 8'h00);
      stat(8'h00);
   endtask

   ////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (16) @(negedge clk_sys);
      sys_rst = 1'b0;
      repeat (4) @(negedge clk_sys);
      cmp({7'h00, miso_oe}, 8'h00);
      fork
         host.xfer('{CMD_READ_NEXT, 8'h00});
         begin
            repeat (20) @(negedge clk_sys);
            cmp({7'h00, miso_oe}, 8'h01);
         end
      join
      cmp(host.got[1], 8'h00);
      round('{8'h02, 8'h64, 8'hFF, 8'h7F, 8'h24, 8'h00},
            '{8'h02, 8'h64, 8'hFF, 8'h7F, 8'h02});
      ls = 8'h5A;
      round('{8'h03, 8'h64, 8'h00, 8'hA6, 8'h00},
            '{8'h03, 8'h64, 8'hFF, 8'h7F, 8'hFF, 8'h7F, 8'h00, 8'h02});
      // Receive fault, then a byte arriving while a message is held
      pulse(rx_err);
      stat(8'h01);
      stat(8'h00);
      back('{8'h11});
      rx_d = 8'h22;
      pulse(rx_v);
      stat(8'h06);
      stat(8'h02);
      host.xfer('{CMD_READ_NEXT, 8'h00});
      cmp(host.got[1], 8'h11);
      stat(8'h00);
      close_out();
   end
endmodule
